// file: common/cfg_regs_map.vh
/*
 Register offsets, field positions and reset values of the converter
 test, range, clock-delay, stabilizer, staging and link registers.
 Assumes 12-bit register addresses and 8-bit data on the config port.
*/
`ifndef CFG_REGS_MAP_VH
`define CFG_REGS_MAP_VH

`define ADDR_W 12
`define N_CHAN 2
`define A_PAT_SEL 12'h014
`define A_PAT_HI 12'h015
`define A_PAT_LO 12'h016
`define A_RNG 12'h017
`define A_CLK_DLY 12'h042
`define A_STAB 12'h043
`define A_STAGE 12'h0FF
`define A_LINK_STAT 12'h801
`define A_LINK_RST 12'h802
`define A_CHAN_SEL 12'h009

`define RST_PAT_SEL 3'h0
`define RST_PAT_HI 8'h00
`define RST_PAT_LO 6'h00
`define RST_RNG_RSV 1'h1
`define RST_RNG_MODE 1'h0
`define RST_RNG_THR 3'h4
`define RST_DLY_RSV 4'h0
`define RST_DLY 4'h0
`define RST_STAB_RSV 6'h31
`define RST_STAB_EDGE 1'h0
`define RST_STAB_SRC 1'h0
`define RST_STAT_RSV 6'h21
`define RST_CHAN_SEL 2'h3
`define RST_STG_DIS 1'h0
`define RST_PULSE 1'h0
`define RST_SYNC 1'h0
`define RST_RDATA 8'h00

`define B_STG_DIS 7
`define B_XFER 6
`define B_SYNC_ERR 7
`define B_PLL_LOCK 0
`define B_SOFT_RST 7
`define B_FRAME_RST 3
`define B_RNG_MODE 3
`define B_RNG_RSV 4
`define B_STAB_EDGE 1
`define B_STAB_SRC 0

`define F_PAT_SEL 2:0
`define F_PAT_HI 7:0
`define F_PAT_LO 7:2
`define F_RNG_THR 2:0
`define F_DLY 3:0
`define F_DLY_RSV 7:4
`define F_STAB_RSV 7:2
`define F_STAT_RSV 6:1
`define F_CHAN_SEL 1:0

`endif

// file: logic/converter_test_sync_config_regs.v
/*
 Configuration and status registers for a dual-channel converter with
 serial outputs: test pattern, range detection, clock delay, stabilizer
 reset, staged update and link status/reset.
 Assumes a decoded config port on clk delivering one-cycle wr/rd strobes,
 and sync error events from link logic on the same clock.
*/
// Operation
// - Upper pattern register holds pattern bits 13..6, reset zero.
// - Lower pattern register bits 7..2 hold pattern bits 5..0.
// - Range mode bit: 0 full-scale detection, 1 fast detection.
// - Four-bit clock delay in half-period steps, reset zero.
// - Stabilizer reset edge: 0 falling, 1 rising.
// - Stabilizer reset source: 0 sync pair, 1 sysref pair.
// - Staging disable 0 stages writes; 1 applies each write directly.
// - Writing transfer bit applies stored settings, then bit self-clears.
// - Read-only sync error flag at link status bit 7.
// - Link soft reset bit restores link defaults, self-clears.
// - Frame builder reset clears sync error flag, self-clears.
// - Local register writes apply to selected channels only; reads show channel A if selected, else channel B.
`timescale 1ns/1ps
`include "cfg_regs_map.vh"
module converter_test_sync_config_regs (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Configuration port
   input wire [`ADDR_W-1:0] addr,
   input wire wr,
   input wire rd,
   input wire [7:0] wdata,
   output reg [7:0] rdata,
   // Link status in
   input wire sync_err_event,
   input wire pll_lock,
   // Applied settings, channel A then B
   output reg [5:0] pattern_choice,
   output reg [27:0] custom_pattern_value,
   output reg [1:0] quick_range_mode,
   output reg [5:0] quick_range_threshold,
   output reg [3:0] clock_delay,
   output reg stabilizer_reset_edge,
   output reg stabilizer_reset_source,
   // Link resets
   output wire link_soft_reset,
   output wire frame_builder_reset
);

   // Field widths of one channel's local settings
   localparam SEL_W = 3;
   localparam HI_W = 8;
   localparam LO_W = 6;
   localparam PAT_W = HI_W + LO_W;
   localparam THR_W = 3;

   // Global settings, shadow (written) copies
   reg [3:0] dly_w_q;
   reg [3:0] dly_rsv_q;
   reg edge_w_q;
   reg src_w_q;
   reg [5:0] stab_rsv_q;
   reg rng_rsv_q;
   reg [1:0] chan_q;
   reg stage_dis_q;

   // Link registers
   reg [5:0] stat_rsv_q;
   reg xfer_q;
   reg sync_err_q;
   reg soft_rst_q;
   reg frame_rst_q;

   // Lock synchroniser, only the second stage is read
   reg pll_s1_q;
   reg pll_s2_q;

   // Read data before the output register
   reg [7:0] rdata_d;

   // Per-channel shadows, flattened with channel A in the low slice
   wire [`N_CHAN*SEL_W-1:0] sel_w;
   wire [`N_CHAN*PAT_W-1:0] pat_w;
   wire [`N_CHAN-1:0] mode_w;
   wire [`N_CHAN*THR_W-1:0] thr_w;

   // Read side view of channel A when it is selected, else of channel B
   wire [SEL_W-1:0] sel_rd;
   wire [PAT_W-1:0] pat_rd;
   wire mode_rd;
   wire [THR_W-1:0] thr_rd;

   wire wr_link_rst;
   wire apply_now;
   genvar ch;

   function is_addr;
      input [`ADDR_W-1:0] a;
      input [`ADDR_W-1:0] b;
      begin
         is_addr = wr && (a == b);
      end
   endfunction

   assign wr_link_rst = is_addr(addr, `A_LINK_RST);
   // Active copies follow the shadows on a transfer or on any write when
   // staging is off; the apply lags the write by one cycle.
   assign apply_now = xfer_q | stage_dis_q;
   assign link_soft_reset = soft_rst_q;
   // Soft reset covers the frame builder as well
   assign frame_builder_reset = frame_rst_q | soft_rst_q;

   // Local writes land only in the selected channels
   generate
      for (ch = 0; ch < `N_CHAN; ch = ch + 1) begin : g_chan
         reg [SEL_W-1:0] sel_q;
         reg [HI_W-1:0] hi_q;
         reg [LO_W-1:0] lo_q;
         reg mode_q;
         reg [THR_W-1:0] thr_q;

         always @(posedge clk) begin
            if (!nrst) begin
               sel_q <= `RST_PAT_SEL;
               hi_q <= `RST_PAT_HI;
               lo_q <= `RST_PAT_LO;
               mode_q <= `RST_RNG_MODE;
               thr_q <= `RST_RNG_THR;
            end else if (chan_q[ch]) begin
               if (is_addr(addr, `A_PAT_SEL))
                  sel_q <= wdata[`F_PAT_SEL];
               if (is_addr(addr, `A_PAT_HI))
                  hi_q <= wdata[`F_PAT_HI];
               if (is_addr(addr, `A_PAT_LO))
                  lo_q <= wdata[`F_PAT_LO];
               if (is_addr(addr, `A_RNG)) begin
                  mode_q <= wdata[`B_RNG_MODE];
                  thr_q <= wdata[`F_RNG_THR];
               end
            end
         end

         assign sel_w[ch*SEL_W +: SEL_W] = sel_q;
         assign pat_w[ch*PAT_W +: PAT_W] = {hi_q, lo_q};
         assign mode_w[ch] = mode_q;
         assign thr_w[ch*THR_W +: THR_W] = thr_q;
      end
   endgenerate

   // Reads return channel A when it is selected, else channel B
   assign sel_rd = chan_q[0] ? sel_w[SEL_W-1:0] : sel_w[2*SEL_W-1:SEL_W];
   assign pat_rd = chan_q[0] ? pat_w[PAT_W-1:0] : pat_w[2*PAT_W-1:PAT_W];
   assign mode_rd = chan_q[0] ? mode_w[0] : mode_w[1];
   assign thr_rd = chan_q[0] ? thr_w[THR_W-1:0] : thr_w[2*THR_W-1:THR_W];

   // Global settings and the channel selection
   always @(posedge clk) begin
      if (!nrst) begin
         dly_w_q <= `RST_DLY;
         dly_rsv_q <= `RST_DLY_RSV;
         edge_w_q <= `RST_STAB_EDGE;
         src_w_q <= `RST_STAB_SRC;
         stab_rsv_q <= `RST_STAB_RSV;
         rng_rsv_q <= `RST_RNG_RSV;
         chan_q <= `RST_CHAN_SEL;
         stage_dis_q <= `RST_STG_DIS;
      end else begin
         if (is_addr(addr, `A_RNG))
            rng_rsv_q <= wdata[`B_RNG_RSV];
         if (is_addr(addr, `A_CLK_DLY)) begin
            dly_w_q <= wdata[`F_DLY];
            dly_rsv_q <= wdata[`F_DLY_RSV];
         end
         if (is_addr(addr, `A_STAB)) begin
            edge_w_q <= wdata[`B_STAB_EDGE];
            src_w_q <= wdata[`B_STAB_SRC];
            stab_rsv_q <= wdata[`F_STAB_RSV];
         end
         if (is_addr(addr, `A_CHAN_SEL))
            chan_q <= wdata[`F_CHAN_SEL];
         if (is_addr(addr, `A_STAGE))
            stage_dis_q <= wdata[`B_STG_DIS];
      end
   end

   // Link registers and the self-clearing command bits
   always @(posedge clk) begin
      if (!nrst) begin
         stat_rsv_q <= `RST_STAT_RSV;
         xfer_q <= `RST_PULSE;
         soft_rst_q <= `RST_PULSE;
         frame_rst_q <= `RST_PULSE;
      end else begin
         if (is_addr(addr, `A_LINK_STAT))
            stat_rsv_q <= wdata[`F_STAT_RSV];
         // Soft reset of the link restores its own register defaults
         if (soft_rst_q)
            stat_rsv_q <= `RST_STAT_RSV;
         // Transfer bit stands one cycle, so a read may catch it set
         if (is_addr(addr, `A_STAGE)) begin
            xfer_q <= wdata[`B_XFER];
         end else begin
            xfer_q <= `RST_PULSE;
         end
         // One-cycle pulses; a held bit would reset the link forever
         soft_rst_q <= wr_link_rst & wdata[`B_SOFT_RST];
         frame_rst_q <= wr_link_rst & wdata[`B_FRAME_RST];
      end
   end

   // Applied settings
   always @(posedge clk) begin
      if (!nrst) begin
         pattern_choice <= {`N_CHAN{`RST_PAT_SEL}};
         custom_pattern_value <= {`N_CHAN{`RST_PAT_HI, `RST_PAT_LO}};
         quick_range_mode <= {`N_CHAN{`RST_RNG_MODE}};
         quick_range_threshold <= {`N_CHAN{`RST_RNG_THR}};
         clock_delay <= `RST_DLY;
         stabilizer_reset_edge <= `RST_STAB_EDGE;
         stabilizer_reset_source <= `RST_STAB_SRC;
      end else if (apply_now) begin
         pattern_choice <= sel_w;
         custom_pattern_value <= pat_w;
         quick_range_mode <= mode_w;
         quick_range_threshold <= thr_w;
         clock_delay <= dly_w_q;
         stabilizer_reset_edge <= edge_w_q;
         stabilizer_reset_source <= src_w_q;
      end
   end

   // Lock comes from another domain, two flops before it is read
   always @(posedge clk) begin
      if (!nrst) begin
         pll_s1_q <= `RST_SYNC;
         pll_s2_q <= `RST_SYNC;
      end else begin
         pll_s1_q <= pll_lock;
         pll_s2_q <= pll_s1_q;
      end
   end

   // Sync error: the event sets, and set wins over clearing resets
   always @(posedge clk) begin
      if (!nrst) begin
         sync_err_q <= `RST_SYNC;
      end else begin
         if (sync_err_event)
            sync_err_q <= 1'b1;
         else if (frame_rst_q | soft_rst_q)
            sync_err_q <= `RST_SYNC;
      end
   end

   // Read multiplexer; unmapped addresses read zero
   always @* begin
      rdata_d = `RST_RDATA;
      case (addr)
         `A_PAT_SEL: rdata_d[`F_PAT_SEL] = sel_rd;
         `A_PAT_HI: rdata_d[`F_PAT_HI] = pat_rd[PAT_W-1:LO_W];
         `A_PAT_LO: rdata_d[`F_PAT_LO] = pat_rd[LO_W-1:0];
         `A_RNG: begin
            rdata_d[`B_RNG_RSV] = rng_rsv_q;
            rdata_d[`B_RNG_MODE] = mode_rd;
            rdata_d[`F_RNG_THR] = thr_rd;
         end
         `A_CLK_DLY: begin
            rdata_d[`F_DLY_RSV] = dly_rsv_q;
            rdata_d[`F_DLY] = dly_w_q;
         end
         `A_STAB: begin
            rdata_d[`F_STAB_RSV] = stab_rsv_q;
            rdata_d[`B_STAB_EDGE] = edge_w_q;
            rdata_d[`B_STAB_SRC] = src_w_q;
         end
         `A_STAGE: begin
            rdata_d[`B_STG_DIS] = stage_dis_q;
            rdata_d[`B_XFER] = xfer_q;
         end
         `A_CHAN_SEL: rdata_d[`F_CHAN_SEL] = chan_q;
         `A_LINK_STAT: begin
            rdata_d[`B_SYNC_ERR] = sync_err_q;
            rdata_d[`F_STAT_RSV] = stat_rsv_q;
            rdata_d[`B_PLL_LOCK] = pll_s2_q;
         end
         `A_LINK_RST: begin
            rdata_d[`B_SOFT_RST] = soft_rst_q;
            rdata_d[`B_FRAME_RST] = frame_rst_q;
         end
         default: rdata_d = `RST_RDATA;
      endcase
   end

   // Read data holds between reads so a slow host still sees it
   always @(posedge clk) begin
      if (!nrst)
         rdata <= `RST_RDATA;
      else if (rd)
         rdata <= rdata_d;
   end

endmodule // converter_test_sync_config_regs

// file: testbench/cfg_regs_checker.sv
/* Port assertions for the config register block.
 Assumes the block's single clock and synchronous active-low reset. */
`timescale 1ns/1ps
`include "cfg_regs_map.vh"
module cfg_regs_checker (
   // Clock, reset, config port and lock input
   input wire clk,
   input wire nrst,
   input wire [`ADDR_W-1:0] addr,
   input wire wr,
   input wire rd,
   input wire [7:0] wdata,
   input wire [7:0] rdata,
   input wire pll_lock,
   // Applied settings and pulses
   input wire [27:0] custom_pattern_value,
   input wire [5:0] pattern_choice,
   input wire [3:0] clock_delay,
   input wire stabilizer_reset_edge,
   input wire stabilizer_reset_source,
   input wire link_soft_reset,
   input wire frame_builder_reset
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wire lrst = wr && addr == `A_LINK_RST;
   // Defaults must land while reset is still low, so no disable here
   reset_dflt_a: assert property (disable iff (1'b0)
      !nrst |=> custom_pattern_value == 28'h0 && pattern_choice == 6'h0
      && clock_delay == 4'h0) else $error("defaults missing");
   soft_pulse_a: assert property (lrst && wdata[7] |=>
      link_soft_reset) else $error("soft reset not pulsed");
   soft_clear_a: assert property (link_soft_reset |=>
      !link_soft_reset) else $error("soft reset stuck");
   soft_cause_a: assert property (link_soft_reset |->
      $past(lrst) && $past(wdata[7])) else $error("stray soft reset");
   frame_pulse_a: assert property (lrst && wdata[3] |=>
      frame_builder_reset) else $error("frame reset not pulsed");
   frame_clear_a: assert property (frame_builder_reset |=>
      !frame_builder_reset) else $error("frame reset stuck");
   apply_lag_a: assert property ($changed(clock_delay) ||
      $changed(stabilizer_reset_edge) || $changed(stabilizer_reset_source)
      |-> $past(wr, 2)) else $error("setting moved without write");
   lock_read_a: assert property ($stable(pll_lock)[*4] ##0
      (rd && addr == `A_LINK_STAT) |=> rdata[0] == pll_lock)
      else $error("lock bit wrong");
   cover property (lrst && wdata[3]);
   cover property ($changed(clock_delay));
   cover property (rd && addr == `A_LINK_STAT && !pll_lock);
endmodule // cfg_regs_checker
bind converter_test_sync_config_regs cfg_regs_checker i_chk (.*);

// file: testbench/cfg_host_model.sv
/* Host on the config port: one-cycle write and read strobes.
 Assumes rdata holds from the edge after the read until the next read. */
`timescale 1ns/1ps
`include "cfg_regs_map.vh"
module cfg_host_model (
   // Clock
   input wire clk,
   // Config port, host side
   output logic [`ADDR_W-1:0] addr,
   output logic wr,
   output logic rd,
   output logic [7:0] wdata,
   input wire [7:0] rdata
);
   initial begin
      addr = 12'h000;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
   // Idle lines are inverted so a stale value never passes as fresh
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk);
      #1;
      wr = 1'b0;
      addr = ~a;
      wdata = ~d;
   endtask
   task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      addr = a;
      rd = 1'b1;
      @(posedge clk);
      #1;
      rd = 1'b0;
      addr = ~a;
      @(posedge clk);
      #1;
      d = rdata;
   endtask
endmodule // cfg_host_model

// file: testbench/converter_test_sync_config_regs_tb.sv
/* Self-checking bench for the config register block.
 Assumes the host model drives the port and the checker is bound. */
`timescale 1ns/1ps
`include "cfg_regs_map.vh"
module converter_test_sync_config_regs_tb;
   logic clk, nrst, sync_err_event, pll_lock;
   wire [`ADDR_W-1:0] addr;
   wire wr, rd, stabilizer_reset_edge, stabilizer_reset_source;
   wire link_soft_reset, frame_builder_reset;
   wire [7:0] wdata, rdata;
   wire [5:0] pattern_choice, quick_range_threshold;
   wire [27:0] custom_pattern_value;
   wire [1:0] quick_range_mode;
   wire [3:0] clock_delay;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [7:0] rv;
   logic [11:0] ta [10] = '{12'h014, 12'h015, 12'h016, 12'h017, 12'h042,
      12'h043, 12'h0FF, 12'h801, 12'h802, 12'h100};
   logic [7:0] te [10] = '{8'h00, 8'h00, 8'h00, 8'h14, 8'h00, 8'hC4,
      8'h00, 8'h43, 8'h00, 8'h00};
   converter_test_sync_config_regs i_dut (.*);
   cfg_host_model i_host (.*);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(string n, logic [27:0] e, logic [27:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rchk(logic [11:0] a, logic [7:0] e);
      i_host.rd_reg(a, rv);
      chk("rdata", {20'h0, e}, {20'h0, rv});
   endtask
   task automatic w2();
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic report_and_stop();
      $display("compares %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   initial begin
      nrst = 1'b0;
      sync_err_event = 1'b0;
      pll_lock = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      nrst = 1'b1;
      for (int i = 0; i < 10; i++)
         rchk(ta[i], te[i]);
      $display("test defaults done");
      i_host.wr_reg(`A_CLK_DLY, 8'h05);
      i_host.wr_reg(`A_PAT_HI, 8'hAB);
      i_host.wr_reg(`A_PAT_LO, 8'hCD);
      i_host.wr_reg(`A_PAT_SEL, 8'h03);
      w2();
      chk("delay", 28'h0, {24'h0, clock_delay});
      i_host.wr_reg(`A_STAGE, 8'h40);
      w2();
      chk("delay", 28'h5, {24'h0, clock_delay});
      chk("pat", {2{14'h2AF3}}, custom_pattern_value);
      chk("sel", 28'h1B, {22'h0, pattern_choice});
      rchk(`A_STAGE, 8'h00);
      rchk(`A_PAT_LO, 8'hCC);
      $display("test staging done");
      i_host.wr_reg(`A_CHAN_SEL, 8'h02);
      i_host.wr_reg(`A_RNG, 8'h18);
      i_host.wr_reg(`A_STAGE, 8'h40);
      w2();
      chk("mode", 28'h2, {26'h0, quick_range_mode});
      chk("thr", 28'h4, {22'h0, quick_range_threshold});
      rchk(`A_RNG, 8'h18);
      i_host.wr_reg(`A_CHAN_SEL, 8'h03);
      rchk(`A_RNG, 8'h14);
      $display("test channel done");
      i_host.wr_reg(`A_STAGE, 8'h80);
      for (int v = 1; v < 3; v++) begin
         i_host.wr_reg(`A_STAB, 8'hC4 | v[7:0]);
         w2();
         chk("dcs", v[27:0], {26'h0, stabilizer_reset_edge,
            stabilizer_reset_source});
      end
      $display("test direct done");
      for (int k = 0; k < 2; k++) begin
         sync_err_event = 1'b1;
         @(posedge clk);
         #1;
         sync_err_event = 1'b0;
         rchk(`A_LINK_STAT, 8'hC3);
         i_host.wr_reg(`A_LINK_RST, k ? 8'h80 : 8'h08);
         rchk(`A_LINK_STAT, 8'h43);
         rchk(`A_LINK_RST, 8'h00);
      end
      $display("test link done");
      pll_lock = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      rchk(`A_LINK_STAT, 8'h42);
      $display("test lock done");
      report_and_stop();
   end
endmodule // converter_test_sync_config_regs_tb
